// *** core/upper_data_read_pins.sv ***
// What this block does
// - Upper data pins not selected as port F lines carry word bits 7..15 on each external access.
// - Drive-control bit decides whether upper data pins float when idle.
// - Drive-control bit is writable by software after reset.
// - Each of nine pins works as port F line, direction per pin.
// - Reset selects data bus function on all nine pins.
// - Clearing a pin's pull-up enable bit turns its pull-up off.
// - Read strobe low through the read; all data pins except port F lines are inputs.
// - Data captured when read strobe returns high.
// - Read strobe qualifies address and space selects while low.
// - Drive-control bit decides whether read strobe floats when idle.
// - Setting strobe pull-up disable bit turns its pull-up off.
// - Program select low on program access, data select on data access.
// - Write cycles drive all data pins except port F lines as outputs.
`timescale 1ns/1ps
`include "upper_data_params.svh"
module upper_data_read_pins
  import upper_data_pkg::*;
#(
  parameter int READ_LEN = `READ_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       drive_bit_we_i,
  input  wire logic                       drive_bit_i,
  input  wire logic                       port_cfg_we_i,
  input  wire logic [`UPPER_WIDTH-1:0]    port_sel_i,
  input  wire logic [`UPPER_WIDTH-1:0]    port_dir_i,
  input  wire logic [`UPPER_WIDTH-1:0]    port_out_i,
  input  wire logic [`UPPER_WIDTH-1:0]    port_pull_i,
  input  wire logic                       strobe_pud_i,
  input  wire logic                       read_req_i,
  input  wire logic                       write_req_i,
  input  wire logic                       data_space_i,
  input  wire logic [`ADDR_WIDTH-1:0]     addr_i,
  input  wire logic [`DATA_WIDTH-1:0]     wdata_i,
  input  wire logic [`UPPER_WIDTH-1:0]    upper_data_in_i,
  output logic [`UPPER_WIDTH-1:0]         upper_data_o,
  output logic [`UPPER_WIDTH-1:0]         upper_data_oe_o,
  output logic [`UPPER_WIDTH-1:0]         port_f_pullup_en_o,
  output logic [`UPPER_WIDTH-1:0]         port_f_in_o,
  output logic                            read_strobe_n_o,
  output logic                            read_strobe_oe_o,
  output logic                            read_strobe_pullup_o,
  output logic                            program_space_select_n_o,
  output logic                            data_space_select_n_o,
  output logic [`ADDR_WIDTH-1:0]          low_address_lines_o,
  output logic                            low_data_dir_in_o,
  output logic [`UPPER_WIDTH-1:0]         rdata_upper_o,
  output logic                            rdata_valid_o,
  output logic                            busy_o,
  output logic                            bus_idle_drive_bit_o
);

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg;

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  logic                    drive_bit_reg;
  logic [`UPPER_WIDTH-1:0] sel_reg;
  logic [`UPPER_WIDTH-1:0] dir_reg;
  logic [`UPPER_WIDTH-1:0] out_reg;
  logic [`UPPER_WIDTH-1:0] pull_reg;
  logic                    spud_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive_bit_reg <= `DRIVE_BIT_RESET;
    end else if (drive_bit_we_i) begin
      drive_bit_reg <= drive_bit_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg  <= `PORT_SEL_RESET;
      dir_reg  <= `PORT_DIR_RESET;
      out_reg  <= `PORT_OUT_RESET;
      pull_reg <= `PORT_PULL_RESET;
      spud_reg <= `STROBE_PUD_RESET;
    end else if (port_cfg_we_i) begin
      sel_reg  <= port_sel_i;
      dir_reg  <= port_dir_i;
      out_reg  <= port_out_i;
      pull_reg <= port_pull_i;
      spud_reg <= strobe_pud_i;
    end
  end

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  bus_state_t              state_reg;
  bus_state_t              state_next;
  logic [7:0]              cnt_reg;
  logic                    last_cycle;
  logic [`DATA_WIDTH-1:0]  wdata_reg;
  logic [`ADDR_WIDTH-1:0]  addr_reg;
  logic                    space_reg;

  assign last_cycle = (cnt_reg == 8'(READ_LEN - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (read_req_i) begin
          state_next = BUS_READ;
        end else if (write_req_i) begin
          state_next = BUS_WRITE;
        end
      end
      BUS_READ: begin
        if (last_cycle) begin
          state_next = BUS_IDLE;
        end
      end
      BUS_WRITE: begin
        if (last_cycle) begin
          state_next = BUS_IDLE;
        end
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BUS_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == BUS_IDLE || last_cycle) begin
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wdata_reg <= 16'h0000;
      addr_reg  <= 17'h00000;
      space_reg <= 1'b0;
    end else if (state_reg == BUS_IDLE && (read_req_i || write_req_i)) begin
      wdata_reg <= wdata_i;
      addr_reg  <= addr_i;
      space_reg <= data_space_i;
    end
  end

  // ----------------------------------------
  // Strobe, selects and address pins
  // ----------------------------------------
  logic active_next;
  logic read_next;
  logic write_next;
  logic space_next;
  // Space of the request being taken, not of the previous one
  assign space_next  = (state_reg == BUS_IDLE) ? data_space_i : space_reg;
  assign read_next   = (state_next == BUS_READ);
  assign write_next  = (state_next == BUS_WRITE);
  assign active_next = read_next | write_next;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n_o          <= 1'b1;
      read_strobe_oe_o         <= 1'b0;
      program_space_select_n_o <= 1'b1;
      data_space_select_n_o    <= 1'b1;
      low_address_lines_o      <= 17'h00000;
      low_data_dir_in_o        <= 1'b1;
      busy_o                   <= 1'b0;
    end else begin
      read_strobe_n_o  <= ~read_next;
      read_strobe_oe_o <= active_next | drive_bit_reg;
      // Selects low for reads and writes alike; address latched at start and held after
      program_space_select_n_o <= ~(active_next & ~space_next);
      data_space_select_n_o    <= ~(active_next & space_next);
      if (state_reg == BUS_IDLE && active_next) begin
        low_address_lines_o <= addr_i;
      end
      low_data_dir_in_o <= ~write_next;
      busy_o            <= active_next;
    end
  end

  // ----------------------------------------
  // Upper data pins
  // ----------------------------------------
  logic [`UPPER_WIDTH-1:0] pin_d;
  logic [`UPPER_WIDTH-1:0] pin_oe_d;
  logic [`UPPER_WIDTH-1:0] bus_d;

  assign bus_d = (state_reg == BUS_IDLE) ? wdata_i[`DATA_WIDTH-1:`UPPER_LSB]
                                         : wdata_reg[`DATA_WIDTH-1:`UPPER_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < `UPPER_WIDTH; gi = gi + 1) begin : g_pin
      upper_pin_cell u_cell (
        .bus_drive_i (write_next | (~active_next & drive_bit_reg)),
        .bus_float_i (read_next),
        .bus_data_i  (bus_d[gi]),
        .port_sel_i  (sel_reg[gi]),
        .port_dir_i  (dir_reg[gi]),
        .port_out_i  (out_reg[gi]),
        .pin_o       (pin_d[gi]),
        .pin_oe_o    (pin_oe_d[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      upper_data_o       <= 9'h000;
      upper_data_oe_o    <= 9'h000;
      port_f_pullup_en_o <= 9'h1ff;
      port_f_in_o        <= 9'h000;
      read_strobe_pullup_o <= 1'b1;
      bus_idle_drive_bit_o <= `DRIVE_BIT_RESET;
    end else begin
      upper_data_o         <= pin_d;
      upper_data_oe_o      <= pin_oe_d;
      port_f_pullup_en_o   <= pull_reg;
      port_f_in_o          <= upper_data_in_i;
      read_strobe_pullup_o <= ~spud_reg;
      bus_idle_drive_bit_o <= drive_bit_reg;
    end
  end

  // ----------------------------------------
  // Read capture at strobe release
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_upper_o <= 9'h000;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      if (state_reg == BUS_READ && last_cycle) begin
        rdata_upper_o <= upper_data_in_i;
        rdata_valid_o <= 1'b1;
      end
    end
  end

endmodule : upper_data_read_pins

// *** core/upper_data_params.svh ***
`ifndef UPPER_DATA_PARAMS_SVH
`define UPPER_DATA_PARAMS_SVH

`define UPPER_WIDTH      9
`define UPPER_LSB        7
`define DATA_WIDTH       16
`define ADDR_WIDTH       17
`define DRIVE_BIT_RESET  1'b0
`define PORT_SEL_RESET   9'h000
`define PORT_DIR_RESET   9'h000
`define PORT_OUT_RESET   9'h000
`define PORT_PULL_RESET  9'h1ff
`define STROBE_PUD_RESET 1'b0
`define TRDS_NS          40
`define READ_CYCLES      ((`TRDS_NS + 39) / 40)

`endif

// *** core/upper_data_pkg.sv ***
package upper_data_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage : upper_data_pkg

// *** core/upper_pin_cell.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// One shared data/port pin
// ----------------------------------------
module upper_pin_cell (
  input  wire logic bus_drive_i,
  input  wire logic bus_float_i,
  input  wire logic bus_data_i,
  input  wire logic port_sel_i,
  input  wire logic port_dir_i,
  input  wire logic port_out_i,
  output logic      pin_o,
  output logic      pin_oe_o
);
  always_comb begin
    if (port_sel_i) begin
      pin_o    = port_out_i;
      pin_oe_o = port_dir_i;
    end else begin
      pin_o    = bus_data_i;
      pin_oe_o = bus_drive_i & ~bus_float_i;
    end
  end
endmodule : upper_pin_cell

// *** verification/upper_data_sva.sv ***
`timescale 1ns/1ps
`include "upper_data_params.svh"
// ----
// Read cycle, idle strobe and configuration checks
// ----
module upper_data_sva #(
  parameter int READ_LEN = 1
) (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    drive_bit_we_i,
  input wire logic                    drive_bit_i,
  input wire logic                    port_cfg_we_i,
  input wire logic                    strobe_pud_i,
  input wire logic                    read_req_i,
  input wire logic                    data_space_i,
  input wire logic [`UPPER_WIDTH-1:0] upper_data_in_i,
  input wire logic [`UPPER_WIDTH-1:0] upper_data_oe_o,
  input wire logic                    read_strobe_n_o,
  input wire logic                    read_strobe_oe_o,
  input wire logic                    read_strobe_pullup_o,
  input wire logic                    program_space_select_n_o,
  input wire logic                    data_space_select_n_o,
  input wire logic                    low_data_dir_in_o,
  input wire logic [`UPPER_WIDTH-1:0] rdata_upper_o,
  input wire logic                    rdata_valid_o,
  input wire logic                    busy_o,
  input wire logic                    bus_idle_drive_bit_o
);
  int lo_cnt;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) lo_cnt <= 0;
    else lo_cnt <= read_strobe_n_o ? 0 : lo_cnt + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  rd_start_a: assert property (!busy_o && read_req_i |=> !read_strobe_n_o)
    else $error("strobe not low");
  rd_len_a: assert property ($rose(read_strobe_n_o) |-> lo_cnt == READ_LEN)
    else $error("strobe length");
  rd_only_a: assert property (!read_strobe_n_o |-> lo_cnt < READ_LEN)
    else $error("strobe too long");
  rd_in_a: assert property (!read_strobe_n_o |-> upper_data_oe_o == '0 && low_data_dir_in_o)
    else $error("pins driven in read");
  rd_cap_a: assert property ($rose(read_strobe_n_o) |-> rdata_upper_o == $past(upper_data_in_i))
    else $error("capture wrong");
  rd_valid_a: assert property (rdata_valid_o == $rose(read_strobe_n_o))
    else $error("valid pulse");
  space_sel_a: assert property (!busy_o && read_req_i |=> !read_strobe_n_o &&
    data_space_select_n_o == !$past(data_space_i) && program_space_select_n_o == $past(data_space_i))
    else $error("space select");
  idle_strobe_a: assert property (!busy_o && $stable(bus_idle_drive_bit_o) |->
    read_strobe_n_o && read_strobe_oe_o == bus_idle_drive_bit_o) else $error("idle strobe");
  drive_bit_a: assert property (drive_bit_we_i |=> ##1
    bus_idle_drive_bit_o == $past(drive_bit_i, 2)) else $error("drive bit");
  strobe_pull_a: assert property (port_cfg_we_i |=> ##1
    read_strobe_pullup_o == !$past(strobe_pud_i, 2))
    else $error("strobe pullup");
endmodule : upper_data_sva
bind upper_data_read_pins upper_data_sva #(.READ_LEN(READ_LEN)) sva_i (.clk_i, .rst_b_i,
  .drive_bit_we_i, .drive_bit_i, .port_cfg_we_i, .strobe_pud_i, .read_req_i, .data_space_i,
  .upper_data_in_i, .upper_data_oe_o, .read_strobe_n_o, .read_strobe_oe_o, .read_strobe_pullup_o,
  .program_space_select_n_o, .data_space_select_n_o, .low_data_dir_in_o, .rdata_upper_o,
  .rdata_valid_o, .busy_o, .bus_idle_drive_bit_o);

// *** verification/sram_model.sv ***
`timescale 1ns/1ps
`include "upper_data_params.svh"
// ----
// Memory on the far side
// ----
module sram_model (
  input  wire logic [`ADDR_WIDTH-1:0]  addr_i,
  input  wire logic                    rd_n_i,
  input  wire logic [`UPPER_WIDTH-1:0] pull_i,
  output logic [`UPPER_WIDTH-1:0]      dq_o
);
  logic [`UPPER_WIDTH-1:0] last_reg = 9'h0a5;
  always @* if (!rd_n_i) last_reg = addr_i[8:0] ^ 9'h155;
  // Released bus goes to the pull-ups, else shows the inverse
  always_comb dq_o = !rd_n_i ? addr_i[8:0] ^ 9'h155 : pull_i | ~last_reg;
endmodule : sram_model

// *** verification/tb_upper_data_read_pins.sv ***
`timescale 1ns/1ps
`include "upper_data_params.svh"
module tb_upper_data_read_pins;
  logic        clk_i = '0, rst_b_i = '0, drive_bit_we_i = '0, drive_bit_i = '0;
  logic        port_cfg_we_i = '0, strobe_pud_i = '0, read_req_i = '0, write_req_i = '0;
  logic        data_space_i = '0, read_strobe_n_o, read_strobe_oe_o, read_strobe_pullup_o;
  logic        program_space_select_n_o, data_space_select_n_o, low_data_dir_in_o;
  logic        rdata_valid_o, busy_o, bus_idle_drive_bit_o;
  logic [8:0]  port_sel_i = '0, port_dir_i = '0, port_out_i = '0, port_pull_i = 9'h1ff;
  logic [8:0]  upper_data_in_i, upper_data_o, upper_data_oe_o, port_f_pullup_en_o;
  logic [8:0]  port_f_in_o, rdata_upper_o, pin_q;
  logic [16:0] addr_i = '0, low_address_lines_o;
  logic [15:0] wdata_i = '0;
  int          bad_count = 0, compares = 0, n;
  int          exp_q[$];
  upper_data_read_pins #(.READ_LEN(1)) dut (.clk_i, .rst_b_i, .drive_bit_we_i, .drive_bit_i,
    .port_cfg_we_i, .port_sel_i, .port_dir_i, .port_out_i, .port_pull_i, .strobe_pud_i,
    .read_req_i, .write_req_i, .data_space_i, .addr_i, .wdata_i, .upper_data_in_i, .upper_data_o,
    .upper_data_oe_o, .port_f_pullup_en_o, .port_f_in_o, .read_strobe_n_o, .read_strobe_oe_o,
    .read_strobe_pullup_o, .program_space_select_n_o, .data_space_select_n_o,
    .low_address_lines_o, .low_data_dir_in_o, .rdata_upper_o, .rdata_valid_o, .busy_o,
    .bus_idle_drive_bit_o);
  sram_model mem (.addr_i(low_address_lines_o), .rd_n_i(read_strobe_n_o),
    .pull_i(port_f_pullup_en_o), .dq_o(upper_data_in_i));
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rd(input logic [8:0] g);
    chk(32'(g), exp_q.size() ? 32'(exp_q.pop_front()) : 32'hffffffff);
  endtask : chk_rd
  task automatic cyc(input logic rd, input logic wr);
    @(negedge clk_i);
    read_req_i = rd;
    write_req_i = wr;
    addr_i = 17'($urandom);
    data_space_i = 1'($urandom);
    wdata_i = 16'($urandom);
    if (rd) exp_q.push_back(int'(addr_i[8:0] ^ 9'h155));
    @(negedge clk_i);
    read_req_i = '0;
    write_req_i = '0;
    if (wr && !rd) chk(32'({upper_data_oe_o, upper_data_o, low_data_dir_in_o}),
                       32'({9'h1ff, wdata_i[15:7], 1'b0}));
    if (rd) chk(32'({low_address_lines_o, read_strobe_n_o, upper_data_oe_o}),
                32'({addr_i, 1'b0, 9'h000}));
    n = 0;
    while (busy_o !== 1'b0 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
  endtask : cyc
  task automatic results();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  always @(negedge clk_i) if (rdata_valid_o === 1'b1) chk_rd(rdata_upper_o);
  initial begin
    #(40 * 3000);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(32'ha3f2f5cc));
    repeat (4) @(negedge clk_i);
    rst_b_i = '1;
    repeat (3) @(negedge clk_i);
    chk(32'({port_f_pullup_en_o, upper_data_oe_o}), 32'({9'h1ff, 9'h000}));
    chk(32'({read_strobe_n_o, read_strobe_oe_o, read_strobe_pullup_o}), 32'h5);
    repeat (6) cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b1);
    cyc(1'b1, 1'b1);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_i);
      port_cfg_we_i = k[2];
      port_sel_i = 9'($urandom);
      port_dir_i = 9'($urandom);
      port_out_i = 9'($urandom);
      port_pull_i = 9'($urandom);
      strobe_pud_i = k[0];
      drive_bit_we_i = '1;
      drive_bit_i = k[1];
      if (!k[2]) port_sel_i = '0;
      @(negedge clk_i);
      port_cfg_we_i = '0;
      drive_bit_we_i = '0;
      pin_q = upper_data_in_i;
      @(negedge clk_i);
      chk(32'(port_f_in_o), 32'(pin_q));
      chk(32'(read_strobe_oe_o), 32'(k[1]));
      chk(32'(upper_data_oe_o),
          32'(port_sel_i & port_dir_i | {9{k[1]}} & ~port_sel_i));
      chk(32'(upper_data_o & port_sel_i & port_dir_i),
          32'(port_out_i & port_sel_i & port_dir_i));
      if (k[2]) chk(32'({port_f_pullup_en_o, read_strobe_pullup_o}),
                    32'({port_pull_i, !k[0]}));
      if (!k[2]) cyc(1'b1, 1'b0);
      if (!k[2]) cyc(1'b0, 1'b1);
    end
    repeat (3) @(negedge clk_i);
    chk(32'(exp_q.size()), 32'h0);
    results();
  end
endmodule : tb_upper_data_read_pins
